// ===== rtl/mcadc_regs.vh
`ifndef MCADC_REGS_VH
`define MCADC_REGS_VH
`define MCADC_CLK_NS        100
`define MCADC_CONV_NS       2000
`define MCADC_GAP_NS        2500
`define MCADC_TRACK_NS      1000
`define MCADC_CONV_CYC      ((`MCADC_CONV_NS + `MCADC_CLK_NS - 1) / `MCADC_CLK_NS)
`define MCADC_GAP_CYC       ((`MCADC_GAP_NS + `MCADC_CLK_NS - 1) / `MCADC_CLK_NS)
`define MCADC_SETUP_CYC     2
`define MCADC_HOLD_CYC      2
`define MCADC_TIMEOUT_CYC   200
`define MCADC_MODE_WAIT     1'b0
`define MCADC_MODE_PIPE     1'b1
`define MCADC_CH_W          3
`define MCADC_DATA_W        8
`define MCADC_LSB_HI        7
`define MCADC_LSB_LO        4
`endif

// ===== rtl/mcadc_counter.v
`timescale 1ns/10ps
`default_nettype none
module mcadc_counter
(
    input  wire       clock,
    input  wire       rst,
    input  wire       load,
    input  wire [7:0] loadValue,
    output reg        expired
);
    reg [7:0] count_r;
    always @(posedge clock or posedge rst)
    begin
        if (rst)
        begin
            count_r <= 8'h00;
            expired <= 1'b1;
        end
        else if (load)
        begin
            count_r <= loadValue;
            expired <= (loadValue == 8'h00);
        end
        else if (count_r != 8'h00)
        begin
            count_r <= count_r - 8'h01;
            expired <= (count_r == 8'h01);
        end
    end
endmodule // mcadc_counter
`default_nettype wire

// ===== rtl/mcadc_host.v
// How it works
// [RQ1] Taking chip select and read strobe both low starts a conversion.
// [RQ2] Channel number drives the select pins in plain binary.
// [RQ3] Wait mode: data is taken only once the device drives its result.
// [RQ4] Channel select pins stay stable while chip select and read are low.
// [RQ5] Wait mode: the read ends once the pending line releases.
// [RQ6] Done line is watched; it clears after chip select rises.
// [RQ7] Wait mode: the read is stretched until pending releases, then captured.
// [RQ8] Pipelined mode: address stays valid across the rising read strobe.
// [RQ9] Pipelined mode: each read returns the previous conversion result.
// [RQ10] Pipelined mode: the pending line is ignored.
// [RQ11] Pipelined mode: done low marks a fresh result for the next read.
// [RQ12] Pipelined mode: the next read fetches fresh data and starts anew.
// [RQ13] Pipelined mode: reads are spaced at least 2.5 us apart.
// [RQ14] Wait mode reads run at least the 2 us conversion time.
// [RQ15] The result byte is returned whole; both nibbles come together.
// [RQ16] Result is natural binary, one step per reference span over 256.
// [RQ17] The device is driven only through chip select, read and address.
// [RQ18] Upper and lower nibbles are handed out as one eight-bit value.
// [RQ19] The data bus is sampled only inside a read cycle.
`timescale 1ns/10ps
`default_nettype none
`include "mcadc_regs.vh"
module mcadc_host
(
    input  wire       clock,
    input  wire       rst,
    input  wire       mode,
    input  wire       reqValid,
    input  wire [2:0] reqChannel,
    output reg        reqReady,
    output reg        rspValid,
    output reg  [7:0] rspData,
    output reg  [3:0] rspHigh,
    output reg  [2:0] rspChannel,
    output reg        rspStale,
    output reg        rspTimeout,
    output reg        chipSelectN,
    output reg        readN,
    output reg  [2:0] channelSelect,
    input  wire [7:0] resultBusIn,
    input  wire       resultBusOe,
    input  wire       pendingIn,
    input  wire       doneN
);
    localparam ST_IDLE  = 3'h0;
    localparam ST_SETUP = 3'h1;
    localparam ST_READ  = 3'h2;
    localparam ST_HOLD  = 3'h3;
    localparam ST_GAP   = 3'h4;

    reg [7:0] busS1_r;
    reg [7:0] busS2_r;
    reg       oeS1_r;
    reg       oeS2_r;
    reg       pendS1_r;
    reg       pendS2_r;
    reg       doneS1_r;
    reg       doneS2_r;
    reg [2:0] state_r;
    reg       mode_r;
    reg       fresh_r;
    reg [2:0] prevChannel_r;
    reg [7:0] waitCount_r;
    reg       tLoad;
    reg [7:0] tValue;
    wire      tExpired;

    function [7:0] cyc8;
        input integer n;
        begin
            cyc8 = n[7:0];
        end
    endfunction

    mcadc_counter u_timer
    (
        .clock     (clock),
        .rst       (rst),
        .load      (tLoad),
        .loadValue (tValue),
        .expired   (tExpired)
    );

    // Pins arrive from another chip, so two flops guard every device input.
    always @(posedge clock or posedge rst)
    begin
        if (rst)
        begin
            busS1_r  <= 8'h00;
            busS2_r  <= 8'h00;
            oeS1_r   <= 1'b0;
            oeS2_r   <= 1'b0;
            pendS1_r <= 1'b1;
            pendS2_r <= 1'b1;
            doneS1_r <= 1'b1;
            doneS2_r <= 1'b1;
        end
        else
        begin
            busS1_r  <= resultBusIn;
            busS2_r  <= busS1_r;
            oeS1_r   <= resultBusOe;
            oeS2_r   <= oeS1_r;
            pendS1_r <= pendingIn;
            pendS2_r <= pendS1_r;
            doneS1_r <= doneN;
            doneS2_r <= doneS1_r;
        end
    end

    always @*
    begin
        tLoad  = 1'b0;
        tValue = 8'h00;
        case (state_r)
            ST_IDLE:
            begin
                tLoad  = reqValid;
                tValue = cyc8(`MCADC_SETUP_CYC);
            end
            ST_SETUP:
            begin
                tLoad  = tExpired;
                tValue = cyc8(`MCADC_CONV_CYC); // [RQ14]
            end
            ST_READ:
            begin
                // The pending line reads high once released, so high ends the stretch.
                tLoad  = tExpired && (mode_r == `MCADC_MODE_PIPE || pendS2_r); // [RQ7]
                tValue = cyc8(`MCADC_HOLD_CYC);
            end
            ST_HOLD:
            begin
                tLoad  = tExpired;
                tValue = cyc8(`MCADC_GAP_CYC); // [RQ13]
            end
            default:
            begin
                tLoad  = 1'b0;
                tValue = 8'h00;
            end
        endcase
    end

    always @(posedge clock or posedge rst)
    begin
        if (rst)
        begin
            state_r       <= ST_IDLE;
            mode_r        <= `MCADC_MODE_WAIT;
            fresh_r       <= 1'b0;
            prevChannel_r <= 3'h0;
            waitCount_r   <= 8'h00;
            reqReady      <= 1'b0;
            rspValid      <= 1'b0;
            rspData       <= 8'h00;
            rspHigh       <= 4'h0;
            rspChannel    <= 3'h0;
            rspStale      <= 1'b0;
            rspTimeout    <= 1'b0;
            chipSelectN   <= 1'b1;
            readN         <= 1'b1;
            channelSelect <= 3'h0;
        end
        else
        begin
            rspValid <= 1'b0;
            reqReady <= (state_r == ST_IDLE) && !reqValid;
            if (!doneS2_r)
                fresh_r <= 1'b1; // [RQ11]
            case (state_r)
                ST_IDLE:
                begin
                    if (reqValid)
                    begin
                        mode_r        <= mode;
                        channelSelect <= reqChannel; // [RQ2]
                        state_r       <= ST_SETUP;
                    end
                end
                ST_SETUP:
                begin
                    if (tExpired)
                    begin
                        chipSelectN <= 1'b0; // [RQ1] [RQ17]
                        readN       <= 1'b0;
                        waitCount_r <= 8'h00;
                        state_r     <= ST_READ;
                    end
                end
                ST_READ:
                begin
                    // [RQ4] channelSelect is left untouched while the strobes are low.
                    if (waitCount_r != 8'hff)
                        waitCount_r <= waitCount_r + 8'h01;
                    if (tLoad)
                    begin
                        // [RQ3] [RQ5] [RQ7] [RQ10] [RQ19]
                        rspData    <= busS2_r; // [RQ15] [RQ16] [RQ18]
                        rspHigh    <= busS2_r[`MCADC_LSB_HI:`MCADC_LSB_LO];
                        rspTimeout <= (mode_r == `MCADC_MODE_WAIT) && !oeS2_r;
                        rspStale   <= (mode_r == `MCADC_MODE_PIPE) && !fresh_r; // [RQ9]
                        rspChannel <= (mode_r == `MCADC_MODE_PIPE) ? prevChannel_r
                                                                   : channelSelect;
                        rspValid   <= 1'b1;
                        chipSelectN <= 1'b1; // [RQ6] [RQ8] address stays through the edge
                        readN      <= 1'b1;
                        // A done seen in the capture cycle wins over the clear.
                        fresh_r    <= !doneS2_r; // [RQ12]
                        prevChannel_r <= channelSelect;
                        state_r    <= ST_HOLD;
                    end
                    else if (waitCount_r == cyc8(`MCADC_TIMEOUT_CYC))
                    begin
                        // A dead device must not hang the bus forever.
                        rspData     <= 8'h00;
                        rspHigh     <= 4'h0;
                        rspTimeout  <= 1'b1;
                        rspStale    <= 1'b0;
                        rspChannel  <= channelSelect;
                        rspValid    <= 1'b1;
                        chipSelectN <= 1'b1;
                        readN       <= 1'b1;
                        state_r     <= ST_HOLD;
                    end
                end
                ST_HOLD:
                begin
                    if (tExpired)
                        state_r <= ST_GAP;
                end
                ST_GAP:
                begin
                    if (tExpired)
                        state_r <= ST_IDLE; // [RQ13]
                end
                default:
                begin
                    state_r <= ST_IDLE;
                end
            endcase
        end
    end
endmodule // mcadc_host
`default_nettype wire

// ===== tb/mcadc_dev_model.sv
`timescale 1ns/10ps
`default_nettype none
module mcadc_dev_model
(
    input  wire logic        chipSelectN,
    input  wire logic        readN,
    input  wire logic        mode,
    input  wire logic [2:0]  channelSelect,
    input  wire logic [63:0] analog,
    output logic      [7:0]  resultBusIn,
    output logic             resultBusOe,
    output logic             pendingIn,
    output logic             doneN
);
    logic [7:0] res = 8'h00;
    logic [7:0] bus = 8'h00;
    logic [7:0] smp;
    logic [2:0] chan = 3'h0;
    logic       clr = 1'b0;
    wire        act = !chipSelectN && !readN;
    // A released bus shows the inverse of its last value, so stale data cannot pass.
    assign resultBusIn = resultBusOe ? bus : ~bus;
    initial {resultBusOe, pendingIn, doneN} = 3'b011;
    always @(posedge act)
    begin
        clr = !doneN;
        if (!mode)
            chan = channelSelect;
        bus = res;
        resultBusOe = mode;
        pendingIn = 1'b0;
        #1000 smp = analog[{chan, 3'h0} +: 8];
        #1005 res = smp;
        doneN = 1'b0;
        if (!mode && act)
            {bus, resultBusOe, pendingIn} = {res, 2'b11};
    end
    always @(posedge readN)
        if (mode)
            chan = channelSelect;
    always @(negedge act)
    begin
        resultBusOe = 1'b0;
        if (!mode || clr)
            doneN = 1'b1;
    end
endmodule // mcadc_dev_model
`default_nettype wire

// ===== tb/mcadc_host_monitor.sv
`timescale 1ns/10ps
`default_nettype none
module mcadc_monitor
(
    input wire logic       clock,
    input wire logic       rst,
    input wire logic       mode,
    input wire logic       rspValid,
    input wire logic [7:0] rspData,
    input wire logic [3:0] rspHigh,
    input wire logic       rspTimeout,
    input wire logic       chipSelectN,
    input wire logic       readN,
    input wire logic [2:0] channelSelect,
    input wire logic       pendingIn
);
    logic [7:0] lowCnt_r;
    logic [7:0] hiCnt_r;
    default clocking @(posedge clock); endclocking
    default disable iff (rst);
    always @(posedge clock or posedge rst)
    begin
        if (rst)
        begin
            lowCnt_r <= 8'h00;
            hiCnt_r  <= 8'hff;
        end
        else
        begin
            lowCnt_r <= chipSelectN ? 8'h00 : lowCnt_r + 8'h01;
            hiCnt_r  <= !chipSelectN ? 8'h00 : hiCnt_r + {7'h00, hiCnt_r != 8'hff};
        end
    end
    a_strobe_pair: assert property (chipSelectN == readN)
        else $error("strobes split");
    a_addr_stable: assert property (
        !chipSelectN && $past(!chipSelectN) |-> $stable(channelSelect))
        else $error("address moved in read");
    a_conv_time: assert property ($rose(chipSelectN) |-> lowCnt_r >= 8'h14)
        else $error("read shorter than conversion");
    a_read_gap: assert property ($fell(chipSelectN) |-> hiCnt_r >= 8'h19)
        else $error("reads too close");
    a_timeout_cap: assert property (lowCnt_r <= 8'hc9)
        else $error("read never ends");
    a_wait_pending: assert property (
        $rose(readN) && !mode && !rspTimeout |-> $past(pendingIn, 2))
        else $error("read ended while pending");
    a_rsp_nibble: assert property (rspValid |-> rspHigh == rspData[7:4])
        else $error("upper nibble differs");
    a_rsp_release: assert property (rspValid |-> $rose(chipSelectN))
        else $error("answer not at strobe release");
    c_wait: cover property (rspValid && !mode);
    c_pipe: cover property (rspValid && mode);
    c_gap: cover property ($fell(chipSelectN) && hiCnt_r < 8'h24);
endmodule // mcadc_monitor
bind mcadc_host mcadc_monitor mon (.clock(clock), .rst(rst), .mode(mode), .rspValid(rspValid),
    .rspData(rspData), .rspHigh(rspHigh), .rspTimeout(rspTimeout), .chipSelectN(chipSelectN),
    .readN(readN), .channelSelect(channelSelect), .pendingIn(pendingIn));
`default_nettype wire

// ===== tb/mcadc_host_test.sv
`timescale 1ns/10ps
`default_nettype none
module mcadc_host_test;
    logic        clock, rst, mode, reqValid, reqReady, rspValid, rspStale, rspTimeout;
    logic        chipSelectN, readN, resultBusOe, pendingIn, doneN;
    logic [2:0]  reqChannel, rspChannel, channelSelect;
    logic [7:0]  rspData, resultBusIn;
    logic [3:0]  rspHigh;
    logic [63:0] analog;
    integer      n_mismatch = 0, n_tests = 0, seed = 62216, lastCode = 0, latch = 0, i, k;
    mcadc_host dut (.clock(clock), .rst(rst), .mode(mode), .reqValid(reqValid),
        .reqChannel(reqChannel), .reqReady(reqReady), .rspValid(rspValid), .rspData(rspData),
        .rspHigh(rspHigh), .rspChannel(rspChannel), .rspStale(rspStale),
        .rspTimeout(rspTimeout), .chipSelectN(chipSelectN), .readN(readN),
        .channelSelect(channelSelect), .resultBusIn(resultBusIn), .resultBusOe(resultBusOe),
        .pendingIn(pendingIn), .doneN(doneN));
    mcadc_dev_model dev (.chipSelectN(chipSelectN), .readN(readN), .mode(mode),
        .channelSelect(channelSelect), .analog(analog), .resultBusIn(resultBusIn),
        .resultBusOe(resultBusOe), .pendingIn(pendingIn), .doneN(doneN));
    task chk(input logic ok, input string what);
        n_tests++;
        if (!ok)
        begin
            n_mismatch++;
            $display("BAD %0t %s", $time, what);
        end
    endtask
    task final_report;
        $display("tests %0d mismatches %0d", n_tests, n_mismatch);
        if (n_mismatch == 0 && n_tests > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    // Pipelined reads return the conversion started by the read before.
    task rd(input logic m, input logic [2:0] ch);
        integer     w;
        integer     prev;
        logic [7:0] exp;
        w = 0;
        while (reqReady !== 1'b1 && w < 100)
        begin
            @(negedge clock);
            w++;
        end
        if (w >= 100)
            chk(1'b0, "never ready");
        analog = {$random(seed), $random(seed)};
        {mode, reqChannel, reqValid} = {m, ch, 1'b1};
        exp = m ? lastCode[7:0] : analog[{ch, 3'h0} +: 8];
        lastCode = m ? analog[latch*8 +: 8] : analog[{ch, 3'h0} +: 8];
        prev = latch;
        latch = ch;
        while (rspValid !== 1'b1 && w < 400)
        begin
            @(negedge clock);
            w++;
            if (reqReady !== 1'b1)
                reqValid = 1'b0;
        end
        if (w >= 400)
        begin
            chk(1'b0, "no answer");
            final_report;
        end
        else
        begin
            chk(rspData === exp, "data");
            chk(rspHigh === exp[7:4], "upper nibble");
            chk(rspTimeout === 1'b0, "timeout flag");
            if (!m)
                chk(rspChannel === ch, "channel");
            else
            begin
                chk(rspChannel === prev[2:0], "pipe channel");
                chk(rspStale === 1'b0, "stale flag");
            end
        end
    endtask
    initial
    begin
        clock = 1'b0;
        forever #50 clock = ~clock;
    end
    initial
    begin
        {rst, mode, reqValid, reqChannel, analog} = {3'b100, 3'h0, 64'h0};
        repeat (3) @(negedge clock);
        chk(chipSelectN === 1'b1 && readN === 1'b1, "strobes in reset");
        rst = 1'b0;
        for (k = 0; k < 8; k++)
            rd(1'b0, k[2:0]);
        for (k = 0; k < 6; k++)
        begin
            i = $random(seed);
            rd(1'b1, i[2:0]);
        end
        rd(1'b0, 3'h5);
        final_report;
    end
endmodule // mcadc_host_test
`default_nettype wire
